// [hesr_chk.sv]
// Checker of report bytes, host interrupt and command refusal.
module hesr_chk
	import hesr_pkg::*;
(
	input wire logic          mclk_i,
	input wire logic          rst_i,
	input wire hesr_cmd_req_t cmd_i,
	input wire logic          emergency_halt_input_n_i,
	input wire logic          stack_overflow_i,
	input wire logic          power_up_done_i,
	input wire logic [10:0]   mem_addr_i,
	input wire logic          mem_rd_i,
	input wire logic [7:0]    mem_rdata_o,
	input wire logic          host_irq_o,
	input wire logic [3:0]    axis_execute_o,
	input wire logic [3:0]    axis_emergency_stop_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// A host read of byte address a.
	sequence s_rd(logic [10:0] a);
		mem_rd_i && mem_addr_i == a;
	endsequence
	property p_stop; !emergency_halt_input_n_i |-> axis_emergency_stop_o == 4'hf; endproperty
	a_stop: assert property (p_stop) else $error("axis not stopped");
	property p_noexec; !emergency_halt_input_n_i && cmd_i.valid |=> axis_execute_o == 4'h0; endproperty
	a_noexec: assert property (p_noexec) else $error("command ran during halt");
	property p_halt; $fell(emergency_halt_input_n_i) |-> ##[1:3] host_irq_o; endproperty
	a_halt: assert property (p_halt) else $error("no halt interrupt");
	property p_boot; power_up_done_i |-> ##[1:3] host_irq_o; endproperty
	a_boot: assert property (p_boot) else $error("no boot interrupt");
	property p_stk; stack_overflow_i ##[1:6] s_rd(ADDR_SERVO_CHECK) |-> mem_rdata_o[0]; endproperty
	a_stk: assert property (p_stk) else $error("stack flag missing");
	property p_ign; s_rd(ADDR_CTRL_STAT1) ##0 mem_rdata_o[BIT_IGNORED] |=> host_irq_o; endproperty
	a_ign: assert property (p_ign) else $error("ignored flag without irq");
	property p_conf; s_rd(ADDR_CTRL_STAT1) ##0 mem_rdata_o[BIT_CONFLICT] |=> host_irq_o; endproperty
	a_conf: assert property (p_conf) else $error("conflict flag without irq");
	property p_exec; axis_execute_o != 4'h0 |-> $past(cmd_i.valid); endproperty
	a_exec: assert property (p_exec) else $error("execute without command");
endmodule : hesr_chk
bind hesr_top hesr_chk chk_u (.*);

// [hesr_host.sv]
// Host computer model reading bytes of the shared host memory.
module hesr_host
	import hesr_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic [7:0]  mem_rdata_i,
	output logic      [10:0] mem_addr_o = 11'h7ff,
	output logic             mem_rd_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic need_reset = 1'b0;
	// The address is inverted after release so a stale decode cannot pass.
	task automatic rd(input logic [10:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		mem_addr_o = a;
		mem_rd_o = 1'b1;
		@(posedge mclk_i);
		d = mem_rdata_i;
		if (a == ADDR_SERVO_CHECK && d[0] === 1'b1) need_reset = 1'b1;
		@(negedge mclk_i);
		mem_rd_o = 1'b0;
		mem_addr_o = ~a;
	endtask : rd
endmodule : hesr_host

// [hesr_pkg.sv]
// Package with constants and carrier types of the host event status reporting block.
package hesr_pkg;

	// Shared host memory map (byte addresses of the 2K window).
	localparam logic [10:0] ADDR_ENC_IDX     = 11'h113;
	localparam logic [10:0] ADDR_SERVO_CHECK = 11'h114;
	localparam logic [10:0] ADDR_CTRL_STAT1  = 11'h100;
	localparam logic [10:0] ADDR_HOST_EVENTS = 11'h101;

	// Field positions.
	localparam int BIT_CONFLICT   = 6;
	localparam int BIT_IGNORED    = 7;
	localparam int BIT_STACK_OVF  = 0;
	localparam int BIT_HALT_EVT   = 2;
	localparam int BIT_VEC_OVF    = 3;
	localparam int BIT_RESET_DONE = 4;
	localparam int BIT_RUN_OUT    = 5;

	// Reset value of all report bytes.
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Limits and timing.
	localparam logic [15:0] FERR_LIMIT      = 16'h0300;
	localparam logic [1:0]  VEC_QUEUE_DEPTH = 2'h3;
	localparam int          CLK_HZ          = 100_000_000;
	localparam int          INDEX_PERIOD_MS = 5;
	localparam int          INDEX_CYCLES    = CLK_HZ / 1000 * INDEX_PERIOD_MS;

	// Motion command codes.
	typedef enum logic [2:0] {
		CMD_NONE       = 3'b000,
		CMD_AXIS_MOVE  = 3'b001,
		CMD_START      = 3'b010,
		CMD_VEL_MODE   = 3'b011,
		CMD_STOP       = 3'b100,
		CMD_VEC_CHANGE = 3'b101,
		CMD_VEC_DONE   = 3'b110,
		CMD_RESET      = 3'b111
	} hesr_cmd_t;

	// Per-axis motion state.
	typedef enum logic [1:0] {
		AX_IDLE    = 2'b00,
		AX_RUN     = 2'b01,
		AX_CONTOUR = 2'b10,
		AX_HALTING = 2'b11
	} hesr_axis_t;

	// Command from the host command decoder.
	typedef struct packed {
		logic      valid;
		hesr_cmd_t op;
		logic [3:0] axes;
	} hesr_cmd_req_t;

	// Encoder sense of one axis.
	typedef struct packed {
		logic [15:0] ferr;
		logic        pulse_lost;
		logic        chan_a;
		logic        chan_b;
		logic        index;
	} hesr_enc_t;

endpackage : hesr_pkg

// [hesr_top.sv]
// Host event status reporting: error and event bytes presented in shared host memory.
// How it works
// - Ignored motion command sets bit 7 of controller status one.
// - Move, start or velocity command to a halting axis is ignored.
// - Low nibble of byte 113h holds one encoder fault bit per axis.
// - Fault needs following error above 300h plus lost pulses or single-channel toggling.
// - High nibble of 113h reports index pulses, refreshed every 5 ms.
// - Internal stack overflow sets bit 0 of servo check byte 114h.
// - Emergency halt interrupts host and sets bit 2 of host event flags.
// - Emergency halt stops all four axes with emergency deceleration.
// - Vector change queues three deep; a fourth sets host event bit 3.
// - Power-up or reset command completion sets host event bit 4.
// - Contour mixed with move or velocity on one axis sets bit 6, discarded.
module hesr_top
	import hesr_pkg::*;
(
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	input  wire hesr_cmd_req_t cmd_i,
	input  wire hesr_enc_t     enc_i [4],
	input  wire logic [3:0]    axis_at_rest_i,
	input  wire logic [3:0]    axis_moving_i,
	input  wire logic          emergency_halt_input_n_i,
	input  wire logic          stack_overflow_i,
	input  wire logic          power_up_done_i,
	input  wire logic          reset_cmd_done_i,
	input  wire logic [7:0]    ring_write_pointer_i,
	input  wire logic [7:0]    ring_read_pointer_i,
	input  wire logic          report_clear_i,
	input  wire logic [10:0]   mem_addr_i,
	input  wire logic          mem_rd_i,
	output logic [7:0]         mem_rdata_o,
	output logic               host_irq_o,
	output logic [3:0]         axis_execute_o,
	output hesr_cmd_t          axis_op_o,
	output logic [3:0]         axis_emergency_stop_o
);

	hesr_axis_t  axis_reg [4];
	hesr_axis_t  axis_next [4];
	logic [7:0]  stat1_reg, stat1_next;
	logic [7:0]  events_reg, events_next;
	logic [7:0]  enc_idx_reg, enc_idx_next;
	logic [7:0]  servo_reg, servo_next;
	logic [1:0]  vec_depth_reg, vec_depth_next;
	logic [3:0]  index_seen_reg;
	logic [31:0] tick_reg;
	logic        halt_prev_reg;
	logic [3:0]  exec_reg;
	hesr_cmd_t   op_reg;
	logic        irq_reg;

	// Emergency halt level and its leading edge; only the edge raises the event flag.
	wire logic halt_active = ~emergency_halt_input_n_i;
	wire logic halt_rise   = halt_active & ~halt_prev_reg;

	// Motion commands are the only ones that can be ignored or flagged as a conflict.
	wire logic is_motion   = cmd_i.valid & (cmd_i.op == CMD_AXIS_MOVE
		| cmd_i.op == CMD_START | cmd_i.op == CMD_VEL_MODE);

	// One-hot views of the axis states, so that each refusal test is a single mask.
	logic [3:0] ax_halting, ax_contour, ax_run;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			ax_halting[i] = axis_reg[i] == AX_HALTING;
			ax_contour[i] = axis_reg[i] == AX_CONTOUR;
			ax_run[i]     = axis_reg[i] == AX_RUN;
		end
	end

	// Refusals: a halting axis outranks a mode conflict, so one command sets one flag.
	wire logic ignored  = is_motion & (|(cmd_i.axes & ax_halting));
	wire logic conflict = is_motion & ~ignored & (
		((cmd_i.op != CMD_START) & (|(cmd_i.axes & ax_contour)))
		| ((cmd_i.op == CMD_START) & (|(cmd_i.axes & ax_run))));
	// Nothing is started while the halt input is low, even on an axis at rest.
	wire logic accept   = is_motion & ~ignored & ~conflict & ~halt_active;

	// Vector change queue traffic; a push onto a full queue is the overflow.
	wire logic vec_push = cmd_i.valid & (cmd_i.op == CMD_VEC_CHANGE);
	wire logic vec_pop  = cmd_i.valid & (cmd_i.op == CMD_VEC_DONE);
	wire logic vec_ovf  = vec_push & (vec_depth_reg == VEC_QUEUE_DEPTH);

	// Run-out needs an empty ring while a contouring axis still moves.
	wire logic ring_empty = ring_write_pointer_i == ring_read_pointer_i;
	wire logic run_out    = ring_empty & (|(axis_moving_i & ax_contour));

	// Last cycle of each index sampling window.
	wire logic tick     = tick_reg == 32'(INDEX_CYCLES - 1);

	// Encoder fault detection per axis.
	// Single-channel toggling is seen as the two channels disagreeing while the error is large.
	logic [3:0] enc_fault, enc_index;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			enc_fault[i] = (enc_i[i].ferr > FERR_LIMIT)
				& (enc_i[i].pulse_lost | (enc_i[i].chan_a ^ enc_i[i].chan_b));
			enc_index[i] = enc_i[i].index;
		end
	end

	// Axis state next values; halting ends only when the axis reaches rest.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			axis_next[i] = axis_reg[i];
			if (halt_active && axis_reg[i] != AX_IDLE) begin
				axis_next[i] = AX_HALTING;
			end else if (axis_reg[i] == AX_HALTING) begin
				if (axis_at_rest_i[i]) begin
					axis_next[i] = AX_IDLE;
				end
			end else if (cmd_i.valid && cmd_i.axes[i]) begin
				case (cmd_i.op)
					CMD_STOP:      axis_next[i] = (axis_reg[i] == AX_IDLE) ? AX_IDLE : AX_HALTING;
					CMD_AXIS_MOVE,
					CMD_VEL_MODE:  if (accept) axis_next[i] = AX_RUN;
					CMD_START:     if (accept) axis_next[i] = AX_CONTOUR;
					default:       axis_next[i] = axis_reg[i];
				endcase
			end else if (axis_reg[i] != AX_IDLE && axis_at_rest_i[i] && !axis_moving_i[i]
				&& axis_reg[i] == AX_RUN) begin
				axis_next[i] = AX_IDLE;
			end
		end
	end

	// Sticky report bytes: a set in the same cycle as a clear wins.
	always_comb begin
		stat1_next  = report_clear_i ? BYTE_RESET : stat1_reg;
		events_next = report_clear_i ? BYTE_RESET : events_reg;
		servo_next  = report_clear_i ? BYTE_RESET : servo_reg;
		if (ignored)  stat1_next[BIT_IGNORED]  = 1'b1;
		if (conflict) stat1_next[BIT_CONFLICT] = 1'b1;
		if (halt_rise) events_next[BIT_HALT_EVT] = 1'b1;
		if (vec_ovf)  events_next[BIT_VEC_OVF]  = 1'b1;
		if (power_up_done_i | reset_cmd_done_i) events_next[BIT_RESET_DONE] = 1'b1;
		if (run_out)  events_next[BIT_RUN_OUT]  = 1'b1;
		if (stack_overflow_i) servo_next[BIT_STACK_OVF] = 1'b1;
		// Encoder faults latch; index nibble is replaced only at each tick.
		enc_idx_next[3:0] = (report_clear_i ? 4'h0 : enc_idx_reg[3:0]) | enc_fault;
		enc_idx_next[7:4] = tick ? (index_seen_reg | enc_index) : enc_idx_reg[7:4];
	end

	// Vector change queue depth; overflow commands are dropped.
	// A pop on an empty queue is ignored, so a stray completion cannot underflow it.
	always_comb begin
		vec_depth_next = vec_depth_reg;
		if (vec_push && !vec_ovf && !vec_pop) begin
			vec_depth_next = vec_depth_reg + 2'h1;
		end else if (vec_pop && !vec_push && vec_depth_reg != 2'h0) begin
			vec_depth_next = vec_depth_reg - 2'h1;
		end
	end

	// Host reads of the shared memory window; unmapped addresses read zero.
	assign mem_rdata_o = !mem_rd_i ? 8'h00 :
		(mem_addr_i == ADDR_ENC_IDX)     ? enc_idx_reg :
		(mem_addr_i == ADDR_SERVO_CHECK) ? servo_reg :
		(mem_addr_i == ADDR_CTRL_STAT1)  ? stat1_reg :
		(mem_addr_i == ADDR_HOST_EVENTS) ? events_reg : 8'h00;

	// Outputs come straight from registers, except the halt request, which must not wait.
	assign host_irq_o            = irq_reg;
	assign axis_execute_o        = exec_reg;
	assign axis_op_o             = op_reg;
	assign axis_emergency_stop_o = {4{halt_active}};

	// Axis states and queue depth; reset leaves every axis at rest.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) axis_reg[i] <= AX_IDLE;
			vec_depth_reg  <= 2'h0;
			halt_prev_reg  <= 1'b0;
		end else begin
			axis_reg       <= axis_next;
			vec_depth_reg  <= vec_depth_next;
			halt_prev_reg  <= halt_active;
		end
	end

	// Report bytes read by the host.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			stat1_reg      <= BYTE_RESET;
			events_reg     <= BYTE_RESET;
			enc_idx_reg    <= BYTE_RESET;
			servo_reg      <= BYTE_RESET;
		end else begin
			stat1_reg      <= stat1_next;
			events_reg     <= events_next;
			enc_idx_reg    <= enc_idx_next;
			servo_reg      <= servo_next;
		end
	end

	// Execute strobe, accepted operation and host interrupt.
	// The interrupt is taken from the next values so it rises with the flag it reports.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			exec_reg       <= 4'h0;
			op_reg         <= CMD_NONE;
			irq_reg        <= 1'b0;
		end else begin
			exec_reg       <= accept ? cmd_i.axes : 4'h0;
			op_reg         <= accept ? cmd_i.op : CMD_NONE;
			irq_reg        <= (|stat1_next[7:6]) | (|events_next);
		end
	end

	// Index sampling window of 5 ms; pulses seen inside it are reported at its end.
	// The nibble is a snapshot, not a count: several pulses in one window read as one,
	// and the host sees a pulse up to one window late.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_reg       <= 32'h0000_0000;
			index_seen_reg <= 4'h0;
		end else begin
			tick_reg       <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
			index_seen_reg <= tick ? 4'h0 : (index_seen_reg | enc_index);
		end
	end

endmodule : hesr_top

// [tb_host_event_status_reporting.sv]
// Self-checking bench of the host event status reporting block.
module tb_host_event_status_reporting
	import hesr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [3:0] k; logic [10:0] a; logic [7:0] e;} hesr_row_t;
	logic          mclk_i = 1'b0, rst_i, emergency_halt_input_n_i, stack_overflow_i;
	logic          power_up_done_i, reset_cmd_done_i, report_clear_i, mem_rd_i, host_irq_o;
	hesr_cmd_req_t cmd_i;
	hesr_enc_t     enc_i [4];
	hesr_cmd_t     axis_op_o;
	logic [3:0]    axis_at_rest_i, axis_moving_i, axis_execute_o, axis_emergency_stop_o;
	logic [7:0]    ring_write_pointer_i, ring_read_pointer_i, mem_rdata_o, d;
	logic [10:0]   mem_addr_i;
	int            err_total = 0, n_compared = 0;
	// Cause, byte read afterwards and its expected value.
	hesr_row_t rows [11] = '{'{4'h0, ADDR_SERVO_CHECK, 8'h01}, '{4'h1, ADDR_HOST_EVENTS, 8'h10},
		'{4'h2, ADDR_HOST_EVENTS, 8'h10}, '{4'h3, ADDR_HOST_EVENTS, 8'h04},
		'{4'h4, ADDR_HOST_EVENTS, 8'h08}, '{4'h5, ADDR_ENC_IDX, 8'h01}, '{4'h6, ADDR_ENC_IDX, 8'h00},
		'{4'h7, ADDR_ENC_IDX, 8'h08}, '{4'h8, ADDR_CTRL_STAT1, 8'h40},
		'{4'h9, ADDR_CTRL_STAT1, 8'h80}, '{4'ha, ADDR_HOST_EVENTS, 8'h20}};
	logic [10:0] adrs [5] = '{ADDR_ENC_IDX, ADDR_SERVO_CHECK, ADDR_CTRL_STAT1, ADDR_HOST_EVENTS, 11'h7ff};
	hesr_top dut_u (.*);
	hesr_host host_u (.mclk_i, .mem_rdata_i(mem_rdata_o), .mem_addr_o(mem_addr_i), .mem_rd_o(mem_rd_i));
	// Free-running 100 MHz clock.
	always #5 mclk_i = ~mclk_i;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Reset also restores every input, so each case starts from idle axes.
	task automatic rst(input int n);
		rst_i = 1'b1;
		{cmd_i, axis_at_rest_i, axis_moving_i, stack_overflow_i, power_up_done_i} = '0;
		{reset_cmd_done_i, report_clear_i, ring_read_pointer_i} = '0;
		enc_i = '{default: '0};
		emergency_halt_input_n_i = 1'b1;
		ring_write_pointer_i = 8'h01;
		repeat (n) @(negedge mclk_i);
		rst_i = 1'b0;
	endtask : rst
	task automatic pulse(ref logic s);
		@(negedge mclk_i);
		s = 1'b1;
		@(negedge mclk_i);
		s = 1'b0;
	endtask : pulse
	task automatic cmd(input hesr_cmd_t op, input logic [3:0] ax);
		@(negedge mclk_i);
		cmd_i = '{1'b1, op, ax};
		@(negedge mclk_i);
		cmd_i = '0;
	endtask : cmd
	task automatic cause(input logic [3:0] k);
		case (k)
			4'h0: pulse(stack_overflow_i);
			4'h1: pulse(power_up_done_i);
			4'h2: pulse(reset_cmd_done_i);
			4'h3: begin
				emergency_halt_input_n_i = 1'b0;
				repeat (3) @(negedge mclk_i);
				cmd(CMD_AXIS_MOVE, 4'hf);
			end
			4'h4: repeat (4) cmd(CMD_VEC_CHANGE, 4'h1);
			4'h5, 4'h6: enc_i[0] = '{(k == 4'h5) ? 16'h0301 : 16'h0300, 1'b1, 1'b0, 1'b0, 1'b0};
			4'h7: enc_i[3] = '{16'h0301, 1'b0, 1'b1, 1'b0, 1'b0};
			4'h8: begin
				cmd(CMD_START, 4'h1);
				cmd(CMD_AXIS_MOVE, 4'h1);
			end
			4'h9: begin
				cmd(CMD_AXIS_MOVE, 4'h1);
				cmd(CMD_STOP, 4'h1);
				cmd(CMD_VEL_MODE, 4'h1);
			end
			default: begin
				cmd(CMD_START, 4'h1);
				ring_read_pointer_i = 8'h01;
				axis_moving_i = 4'h1;
			end
		endcase
		repeat (2) @(negedge mclk_i);
	endtask : cause
	task automatic report_and_stop;
		if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	// Watchdog sized far above the few hundred cycles the cases need.
	initial begin
		#200_000;
		err_total++;
		report_and_stop();
	end
	initial begin
		rst(12);
		foreach (rows[i]) begin
			cause(rows[i].k);
			host_u.rd(rows[i].a, d);
			chk(d, rows[i].e);
			rst(2);
		end
		chk({7'h00, host_u.need_reset}, 8'h01);
		foreach (adrs[i]) begin
			host_u.rd(adrs[i], d);
			chk(d, 8'h00);
		end
		cmd(CMD_AXIS_MOVE, 4'h2);
		chk({4'h0, axis_execute_o}, 8'h02);
		chk({5'h00, axis_op_o}, 8'h01);
		cmd(CMD_STOP, 4'h2);
		cmd(CMD_VEL_MODE, 4'h2);
		chk({4'h0, axis_execute_o}, 8'h00);
		@(negedge mclk_i);
		chk({7'h00, host_irq_o}, 8'h01);
		pulse(report_clear_i);
		@(negedge mclk_i);
		chk({7'h00, host_irq_o}, 8'h00);
		// Start on a running axis is a conflict and does not run.
		rst(2);
		cmd(CMD_VEL_MODE, 4'h4);
		cmd(CMD_START, 4'h4);
		chk({4'h0, axis_execute_o}, 8'h00);
		host_u.rd(ADDR_CTRL_STAT1, d);
		chk(d, 8'h40);
		// A stopped axis that reaches rest takes a new move again.
		cmd(CMD_STOP, 4'h4);
		axis_at_rest_i = 4'h4;
		cmd(CMD_AXIS_MOVE, 4'h4);
		axis_at_rest_i = 4'h0;
		chk({4'h0, axis_execute_o}, 8'h04);
		// Halt input drives the stop request and makes the moving axis refuse motion.
		emergency_halt_input_n_i = 1'b0;
		@(negedge mclk_i);
		chk({4'h0, axis_emergency_stop_o}, 8'h0f);
		emergency_halt_input_n_i = 1'b1;
		cmd(CMD_AXIS_MOVE, 4'h4);
		host_u.rd(ADDR_CTRL_STAT1, d);
		chk(d, 8'hc0);
		chk({4'h0, axis_emergency_stop_o}, 8'h00);
		// A pop frees one level of the vector queue; the next push past three overflows.
		rst(2);
		repeat (3) cmd(CMD_VEC_CHANGE, 4'h1);
		cmd(CMD_VEC_DONE, 4'h1);
		cmd(CMD_VEC_CHANGE, 4'h1);
		host_u.rd(ADDR_HOST_EVENTS, d);
		chk(d, 8'h00);
		cmd(CMD_VEC_CHANGE, 4'h1);
		host_u.rd(ADDR_HOST_EVENTS, d);
		chk(d, 8'h08);
		// Large error with healthy channels is no fault; an index waits for the window end.
		enc_i[1] = '{16'hffff, 1'b0, 1'b1, 1'b1, 1'b1};
		repeat (2) @(negedge mclk_i);
		host_u.rd(ADDR_ENC_IDX, d);
		chk(d, 8'h00);
		report_and_stop();
	end
endmodule : tb_host_event_status_reporting
